// File: hw/sfpi_consts.svh
`ifndef SFPI_CONSTS_SVH
`define SFPI_CONSTS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define SFPI_CMD_READ      8'h03
`define SFPI_CMD_READ_DUAL 8'h3B
`define SFPI_CMD_READ_QUAD 8'h6B
`define SFPI_CMD_WR_STAT   8'h01

// ----------------------------------------------------------------------------
// Frame counts and lane steps
// ----------------------------------------------------------------------------
`define SFPI_BIT_LAST      3'h7
`define SFPI_ADDR_LAST     2'h2
`define SFPI_BITS_BYTE     4'h8
`define SFPI_STEP1         4'h1
`define SFPI_STEP2         4'h2
`define SFPI_STEP4         4'h4

// ----------------------------------------------------------------------------
// Output enables (low drives) and reset values
// ----------------------------------------------------------------------------
`define SFPI_OE_NONE       4'hF
`define SFPI_OE_SINGLE     4'hD
`define SFPI_OE_DUAL       4'hC
`define SFPI_OE_QUAD       4'h0
`define SFPI_STAT_RST      7'h00

`endif

// File: hw/sfpi_pkg.sv
package sfpi_pkg;

    // ------------------------------------------------------------------------
    // Link states, lane modes and status layout
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {SFPI_ST_CMD, SFPI_ST_ADDR, SFPI_ST_DUMMY,
                              SFPI_ST_DATA, SFPI_ST_WRS, SFPI_ST_DONE} sfpi_state_t;
    typedef enum logic [1:0] {SFPI_LANE1, SFPI_LANE2, SFPI_LANE4} sfpi_lane_t;

    // Status register bits that steer protection and quad mode.
    typedef struct packed {
        logic       quad_enable_bit;        // Reuses protect and hold pins as data.
        logic       protect_complement_bit; // Inverts the protected region.
        logic       protect_granule_bit;    // Selects protection granule size.
        logic       top_bottom_bit;         // Protects from top or bottom.
        logic [2:0] block_protect_field;    // Size of the protected region.
    } sfpi_stat_t;

    // State sampled on the serial clock rising edge.
    typedef struct packed {
        sfpi_state_t state;    // Frame phase.
        logic [2:0]  bit_cnt;  // Bit within the current byte.
        logic [1:0]  byte_cnt; // Address byte index.
        logic [7:0]  sh;       // Inbound shift register.
        logic [7:0]  cmd;      // Command byte of this frame.
        logic [23:0] addr;     // Address of this frame.
        sfpi_lane_t  lanes;    // Lanes used for read data.
        logic        cmd_done; // Level: command and address complete.
        logic        wrs_done; // Level: status byte complete.
        logic        wrs_ok;   // Status byte may be written.
        logic [7:0]  wrs_byte; // Received status byte.
        logic        qe_s1;    // Quad enable synchroniser, first stage.
        logic        qe_s2;    // Quad enable synchroniser, second stage.
    } sfpi_rise_t;

    // State updated on the serial clock falling edge.
    typedef struct packed {
        logic       active;  // First byte already loaded.
        logic [3:0] cnt;     // Bits left in the output byte.
        logic [7:0] sh;      // Outbound shift register.
        logic       parity;  // Flips on each byte load, asks for next byte.
        logic [3:0] io_out;  // Driven data levels.
        logic [3:0] io_oe_n; // Output enables, low drives.
    } sfpi_fall_t;

    // State on the core clock.
    typedef struct packed {
        logic       cs_s1, cs_s2;        // Select synchroniser.
        logic       cd_s1, cd_s2, cd_s3; // Command done synchroniser.
        logic       wd_s1, wd_s2, wd_s3; // Status done synchroniser.
        logic       rp_s1, rp_s2, rp_s3; // Byte request synchroniser.
        sfpi_stat_t stat;                // Status register.
        logic       standby;             // Standby indication.
        logic       cmd_valid;           // Command pulse.
        logic [7:0] cmd_code;            // Command byte.
        logic [23:0] cmd_addr;           // Command address.
        logic       rd_req;              // Read byte request pulse.
        logic [7:0] rd_hold;             // Byte for the link to send.
        logic       wr_blocked;          // Status write refused pulse.
    } sfpi_core_t;

endpackage : sfpi_pkg

// File: hw/sfpi_top.sv
`timescale 1ns/1ps
`include "sfpi_consts.svh"

// Summary of operation
// RULE1: Select edges alone bound each operation.
// RULE2: Deselect enters standby, not deep power-down.
// RULE3: Output line floats while deselected.
// RULE4: Input line ignored while deselected.
// RULE5: Standby waits for internal program/erase end.
// RULE6: Inbound bits sampled on clock rising edge.
// RULE7: Read data shifted out on falling edge.
// RULE8: Host sends all single-lane bits on input.
// RULE9: Multi-lane reads turn input into output zero.
// RULE10: Output line carries lane one in multi-lane.
// RULE11: Write-protect low blocks status register writes.
// RULE12: Quad enable turns protect pin into lane two.
// RULE13: Host holds only when selected, clock low.
// RULE14: Hold freezes clocking, floats output, internal continues. Hold here clears the falling-edge output shifter instead of freezing it.
// RULE15: Hold pin is lane three in quad reads.
// RULE16: Select fall clears counter and command state.
module sfpi_top (
    input  wire logic       core_clk,               // Core clock.
    input  wire logic       rst,                    // Asynchronous reset.
    input  wire logic       sck,                    // Serial clock from host.
    input  wire logic       cs_n,                   // Select, low active.
    input  wire logic [3:0] io_in,                  // Data pin levels.
    output logic      [3:0] io_out,                 // Data pin drive levels.
    output logic      [3:0] io_oe_n,                // Data pin enables, low drives.
    input  wire logic       busy,                   // Internal program/erase runs.
    input  wire logic       rd_valid,               // Read byte supplied.
    input  wire logic [7:0] rd_data,                // Read byte.
    output logic            rd_req,                 // Next read byte wanted.
    output logic            cmd_valid,              // Command received.
    output logic      [7:0] cmd_code,               // Command byte.
    output logic     [23:0] cmd_addr,               // Command address.
    output logic            wr_blocked,             // Status write refused.
    output logic            standby,                // Standby indication.
    output logic            quad_enable_bit,        // Status bit.
    output logic            protect_complement_bit, // Status bit.
    output logic            protect_granule_bit,    // Status bit.
    output logic            top_bottom_bit,         // Status bit.
    output logic      [2:0] block_protect_field     // Status field.
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    sfpi_pkg::sfpi_rise_t rise_r, rise_nxt; // Rising edge domain.
    sfpi_pkg::sfpi_fall_t fall_r, fall_nxt; // Falling edge domain.
    sfpi_pkg::sfpi_core_t core_r, core_nxt; // Core domain.
    logic                 hold_act;         // Hold pause in effect.
    logic                 link_rst;         // Clears the frame logic.
    logic                 fall_rst;         // Floats and clears the outputs.
    logic [7:0]           cmd_in;           // Command byte as it completes.

    // Hold counts only while the pin is not a data lane.
    assign hold_act = ~io_in[3] & ~rise_r.qe_s2;
    assign link_rst = rst | cs_n;
    assign fall_rst = link_rst | hold_act;
    assign cmd_in   = {rise_r.sh[6:0], io_in[0]};

    // ------------------------------------------------------------------------
    // Rising edge: command, address and status byte intake
    // ------------------------------------------------------------------------
    // Next value of the intake state for each rising serial clock edge.
    always_comb begin
        rise_nxt       = rise_r;
        rise_nxt.qe_s1 = core_r.stat.quad_enable_bit;
        rise_nxt.qe_s2 = rise_r.qe_s1;
        if (!hold_act) begin // [RULE14]
            // Every phase samples lane zero on this edge.
            rise_nxt.sh      = {rise_r.sh[6:0], io_in[0]}; // [RULE6] [RULE8]
            rise_nxt.bit_cnt = rise_r.bit_cnt + 3'h1;
            unique case (rise_r.state)
                sfpi_pkg::SFPI_ST_CMD: begin
                    // Decode once the full command byte is in.
                    if (rise_r.bit_cnt == `SFPI_BIT_LAST) begin
                        rise_nxt.cmd   = cmd_in;
                        rise_nxt.state = sfpi_pkg::SFPI_ST_DONE;
                        if (cmd_in == `SFPI_CMD_READ) begin
                            rise_nxt.state = sfpi_pkg::SFPI_ST_ADDR;
                            rise_nxt.lanes = sfpi_pkg::SFPI_LANE1;
                        end else if (cmd_in == `SFPI_CMD_READ_DUAL) begin
                            rise_nxt.state = sfpi_pkg::SFPI_ST_ADDR;
                            rise_nxt.lanes = sfpi_pkg::SFPI_LANE2;
                        end else if (cmd_in == `SFPI_CMD_READ_QUAD && rise_r.qe_s2) begin
                            rise_nxt.state = sfpi_pkg::SFPI_ST_ADDR;
                            rise_nxt.lanes = sfpi_pkg::SFPI_LANE4;
                        end else if (cmd_in == `SFPI_CMD_WR_STAT) begin
                            rise_nxt.state = sfpi_pkg::SFPI_ST_WRS;
                        end else begin
                            // Other commands are reported and otherwise ignored.
                            rise_nxt.cmd_done = 1'b1;
                        end
                    end
                end
                sfpi_pkg::SFPI_ST_ADDR: begin
                    // Address arrives most significant bit first.
                    rise_nxt.addr = {rise_r.addr[22:0], io_in[0]}; // [RULE6]
                    if (rise_r.bit_cnt == `SFPI_BIT_LAST) begin
                        rise_nxt.byte_cnt = rise_r.byte_cnt + 2'h1;
                        if (rise_r.byte_cnt == `SFPI_ADDR_LAST) begin
                            rise_nxt.state    = sfpi_pkg::SFPI_ST_DUMMY;
                            rise_nxt.cmd_done = 1'b1;
                        end
                    end
                end
                sfpi_pkg::SFPI_ST_DUMMY: begin
                    // One dummy byte gives the core time to fetch data.
                    if (rise_r.bit_cnt == `SFPI_BIT_LAST) begin
                        rise_nxt.state = sfpi_pkg::SFPI_ST_DATA;
                    end
                end
                sfpi_pkg::SFPI_ST_WRS: begin
                    // Protect pin low refuses the write unless it is a lane.
                    if (rise_r.bit_cnt == `SFPI_BIT_LAST) begin
                        rise_nxt.wrs_byte = cmd_in;
                        rise_nxt.wrs_ok   = io_in[2] | rise_r.qe_s2; // [RULE11] [RULE12]
                        rise_nxt.wrs_done = 1'b1;
                        rise_nxt.cmd_done = 1'b1;
                        rise_nxt.state    = sfpi_pkg::SFPI_ST_DONE;
                    end
                end
                sfpi_pkg::SFPI_ST_DATA,
                sfpi_pkg::SFPI_ST_DONE: begin
                    // Further inbound bits are dropped until deselect.
                    rise_nxt.bit_cnt = rise_r.bit_cnt;
                end
            endcase
        end
    end

    // Select high clears the frame, so each select fall starts afresh.
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin // [RULE1] [RULE4] [RULE16]
            rise_r <= '0;
        end else begin
            rise_r <= rise_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Falling edge: read data out on one, two or four lanes
    // ------------------------------------------------------------------------
    // Next value of the output shifter for each falling serial clock edge.
    always_comb begin
        logic [3:0] step;
        logic [7:0] src;
        step     = `SFPI_STEP1;
        src      = fall_r.sh;
        fall_nxt = fall_r;
        unique case (rise_r.lanes)
            sfpi_pkg::SFPI_LANE1: step = `SFPI_STEP1;
            sfpi_pkg::SFPI_LANE2: step = `SFPI_STEP2;
            sfpi_pkg::SFPI_LANE4: step = `SFPI_STEP4;
            default:              step = `SFPI_STEP1;
        endcase
        if (rise_r.state == sfpi_pkg::SFPI_ST_DATA) begin
            // Load a fresh byte when the last one is used up.
            if (!fall_r.active || fall_r.cnt == 4'h0) begin
                src             = core_r.rd_hold;
                fall_nxt.active = 1'b1;
                fall_nxt.parity = ~fall_r.parity;
                fall_nxt.cnt    = `SFPI_BITS_BYTE - step;
            end else begin
                fall_nxt.cnt = fall_r.cnt - step;
            end
            unique case (rise_r.lanes)
                sfpi_pkg::SFPI_LANE1: begin
                    fall_nxt.io_out  = {2'h0, src[7], 1'b0}; // [RULE7]
                    fall_nxt.io_oe_n = `SFPI_OE_SINGLE;
                    fall_nxt.sh      = {src[6:0], 1'b0};
                end
                sfpi_pkg::SFPI_LANE2: begin
                    fall_nxt.io_out  = {2'h0, src[7:6]}; // [RULE9] [RULE10]
                    fall_nxt.io_oe_n = `SFPI_OE_DUAL;
                    fall_nxt.sh      = {src[5:0], 2'h0};
                end
                default: begin
                    fall_nxt.io_out  = src[7:4]; // [RULE9] [RULE10] [RULE12] [RULE15]
                    fall_nxt.io_oe_n = `SFPI_OE_QUAD;
                    fall_nxt.sh      = {src[3:0], 4'h0};
                end
            endcase
        end
    end

    // Deselect or hold floats every lane at once.
    always_ff @(negedge sck or posedge fall_rst) begin
        if (fall_rst) begin // [RULE3] [RULE14]
            fall_r <= '0;
            fall_r.io_oe_n <= `SFPI_OE_NONE;
        end else begin
            fall_r <= fall_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Core clock: crossings, status register, standby
    // ------------------------------------------------------------------------
    // Next value of the core state for each core clock edge.
    always_comb begin
        sfpi_pkg::sfpi_stat_t wr;
        wr                  = rise_r.wrs_byte[6:0];
        core_nxt            = core_r;
        core_nxt.cs_s1      = cs_n;
        core_nxt.cs_s2      = core_r.cs_s1;
        core_nxt.cd_s1      = rise_r.cmd_done;
        core_nxt.cd_s2      = core_r.cd_s1;
        core_nxt.cd_s3      = core_r.cd_s2;
        core_nxt.wd_s1      = rise_r.wrs_done;
        core_nxt.wd_s2      = core_r.wd_s1;
        core_nxt.wd_s3      = core_r.wd_s2;
        core_nxt.rp_s1      = fall_r.parity;
        core_nxt.rp_s2      = core_r.rp_s1;
        core_nxt.rp_s3      = core_r.rp_s2;
        core_nxt.cmd_valid  = 1'b0;
        core_nxt.rd_req     = 1'b0;
        core_nxt.wr_blocked = 1'b0;
        // Standby only after deselect and once internal work is over.
        core_nxt.standby    = core_r.cs_s2 & ~busy; // [RULE2] [RULE5]
        // A completed command is stable on the link side when seen here.
        if (core_r.cd_s2 && !core_r.cd_s3) begin
            core_nxt.cmd_valid = 1'b1;
            core_nxt.cmd_code  = rise_r.cmd;
            core_nxt.cmd_addr  = rise_r.addr;
            core_nxt.rd_req    = (rise_r.state == sfpi_pkg::SFPI_ST_DUMMY);
        end
        // Each byte the link loads asks for the one after it.
        if (!core_r.cs_s2 && core_r.rp_s2 != core_r.rp_s3) begin
            core_nxt.rd_req = 1'b1;
        end
        // The byte is held steady until the link loads it.
        if (rd_valid) begin
            core_nxt.rd_hold = rd_data;
        end
        // Status writes land here, or are refused when protected.
        if (core_r.wd_s2 && !core_r.wd_s3) begin
            if (rise_r.wrs_ok) begin
                core_nxt.stat = wr; // [RULE11]
            end else begin
                core_nxt.wr_blocked = 1'b1;
            end
        end
    end

    // Core state register.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_r         <= '0;
            core_r.cs_s1   <= 1'b1;
            core_r.cs_s2   <= 1'b1;
            core_r.stat    <= `SFPI_STAT_RST;
        end else begin
            core_r <= core_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign io_out                 = fall_r.io_out;
    assign io_oe_n                = fall_r.io_oe_n;
    assign rd_req                 = core_r.rd_req;
    assign cmd_valid              = core_r.cmd_valid;
    assign cmd_code               = core_r.cmd_code;
    assign cmd_addr               = core_r.cmd_addr;
    assign wr_blocked             = core_r.wr_blocked;
    assign standby                = core_r.standby;
    assign quad_enable_bit        = core_r.stat.quad_enable_bit;
    assign protect_complement_bit = core_r.stat.protect_complement_bit;
    assign protect_granule_bit    = core_r.stat.protect_granule_bit;
    assign top_bottom_bit         = core_r.stat.top_bottom_bit;
    assign block_protect_field    = core_r.stat.block_protect_field;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_so_float: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
        cs_n |-> io_oe_n == `SFPI_OE_NONE) else $error("lane driven while deselected");
    a_in_ignored: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
        cs_n |-> rise_r.state == sfpi_pkg::SFPI_ST_CMD && rise_r.bit_cnt == 3'h0)
        else $error("input taken while deselected");
    a_standby_in: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
        (cs_n && !busy) [*4] |-> standby) else $error("no standby after deselect");
    a_busy_defer: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        busy |=> !standby) else $error("standby during internal work");
    // The status byte ends the frame, so no later rising edge follows it.
    // These checks therefore look at the value that the last edge will load.
    a_wp_block: assert property (@(posedge sck) disable iff (link_rst) // [RULE11]
        rise_r.state == sfpi_pkg::SFPI_ST_WRS && rise_r.bit_cnt == `SFPI_BIT_LAST && !hold_act
        && !io_in[2] && !rise_r.qe_s2 |-> rise_nxt.wrs_done && !rise_nxt.wrs_ok)
        else $error("protected status write accepted");
    a_qe_lane: assert property (@(posedge sck) disable iff (link_rst) // [RULE12]
        rise_r.state == sfpi_pkg::SFPI_ST_WRS && rise_r.bit_cnt == `SFPI_BIT_LAST
        && rise_r.qe_s2 |-> rise_nxt.wrs_ok) else $error("quad mode still protects");
    a_rise_sample: assert property (@(posedge sck) disable iff (link_rst) // [RULE6]
        rise_r.state == sfpi_pkg::SFPI_ST_ADDR && !hold_act
        |=> rise_r.addr[0] == $past(io_in[0])) else $error("address bit not sampled");
    a_fall_shift: assert property (@(negedge sck) disable iff (fall_rst) // [RULE7]
        rise_r.state == sfpi_pkg::SFPI_ST_DATA && rise_r.lanes == sfpi_pkg::SFPI_LANE1
        && fall_r.active && fall_r.cnt != 4'h0
        |=> io_out[1] == $past(fall_r.sh[7]) && !io_oe_n[1]) else $error("bad serial out");
    a_quad_lanes: assert property (@(negedge sck) disable iff (fall_rst) // [RULE9]
        rise_r.state == sfpi_pkg::SFPI_ST_DATA && rise_r.lanes == sfpi_pkg::SFPI_LANE4
        |=> io_oe_n == `SFPI_OE_QUAD) else $error("quad lanes not driven");
    a_hold_pause: assert property (@(posedge sck) disable iff (link_rst) // [RULE14]
        hold_act |=> rise_r.state == $past(rise_r.state) && rise_r.bit_cnt ==
        $past(rise_r.bit_cnt)) else $error("clock counted during hold");
    c_quad_read: cover property (@(negedge sck) rise_r.lanes == sfpi_pkg::SFPI_LANE4
        && fall_r.active);
    c_wrs_blocked: cover property (@(posedge core_clk) wr_blocked);
    c_standby: cover property (@(posedge core_clk) $rose(standby));

endmodule : sfpi_top

// File: tb/sfpi_host.sv
`timescale 1ns/1ps
// Host model: frames select, makes the serial clock only inside frames, resolves the pins.
module sfpi_host (
    output logic            sck,
    output logic            cs_n,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe_n
);
    logic [3:0] drv = 4'h0;  // Host drive levels.
    logic [3:0] en = 4'h0;   // Host drive enables.
    logic       flip = 1'b0; // Changing level seen on a floating line.
    initial sck = 1'b0;
    // Select starts low so that the reset edge reaches the link logic, then rises.
    initial begin
        cs_n = 1'b0;
        #1 cs_n = 1'b1;
    end
    always #3.1 flip = ~flip;
    // Device drive wins, then host; lanes 2 and 3 are pulled up, others wander.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = !io_oe_n[i] ? io_out[i] : en[i] ? drv[i] : (i > 1) | (flip ^ i[0]);
        end
    end
    // Opens a frame with a falling select edge.
    task start;
        #1.3 cs_n = 1'b0;
        #40;
    endtask : start
    // Closes a frame with a rising select edge and releases lanes 0 and 1.
    task stop;
        #40 cs_n = 1'b1;
        en[1:0] = 2'h0;
        #40;
    endtask : stop
    // Sends nb bits MSB first on lane 0, changed after each fall.
    task send(input logic [7:0] v, input int nb);
        for (int b = 7; b > 7 - nb; b--) begin
            drv[0] = v[b];
            en[0] = 1'b1;
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
    endtask : send
    // Captures one byte at rises over ln lanes, highest lane first.
    task recv(input int ln, output logic [7:0] v);
        en[0] = 1'b0;
        if (ln == 4) en[2] = 1'b0;
        for (int s = 0; s < 8 / ln; s++) begin
            #80 sck = 1'b1;
            v = ln == 1 ? {v[6:0], io_in[1]} : ln == 2 ? {v[5:0], io_in[1:0]} : {v[3:0], io_in};
            #80 sck = 1'b0;
        end
    endtask : recv
    // Holds the frame for two clocks whose bits must be ignored; select low, clock low.
    task pause;
        drv[3] = 1'b0;
        en[3] = 1'b1;
        send(8'hFF, 2);
        en[3] = 1'b0;
    endtask : pause
    // Drives the write-protect lane.
    task set_wp(input logic w);
        drv[2] = w;
        en[2] = 1'b1;
    endtask : set_wp
endmodule : sfpi_host

// File: tb/sfpi_top_tb.sv
`timescale 1ns/1ps
// Bench: reads, status writes and framing through the host model.
module sfpi_top_tb;
    logic        core_clk = 1'b0, rst = 1'b0, busy = 1'b0, rd_valid = 1'b0;
    logic [7:0]  rd_data = 8'h00;
    logic        sck, cs_n, rd_req, cmd_valid, wr_blocked, standby;
    logic [3:0]  io_in, io_out, io_oe_n;
    logic [7:0]  cmd_code;
    logic [23:0] cmd_addr;
    logic [6:0]  st;          // Status bits, quad enable on top.
    int          fails = 0, n_checks = 0, nblk = 0, idx = 0;
    sfpi_host h (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
    sfpi_top dut (.core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe_n(io_oe_n), .busy(busy), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_req(rd_req), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .wr_blocked(wr_blocked), .standby(standby),
        .quad_enable_bit(st[6]), .protect_complement_bit(st[5]), .protect_granule_bit(st[4]),
        .top_bottom_bit(st[3]), .block_protect_field(st[2:0]));
    always #2 core_clk = ~core_clk;
    // Byte k of every read.
    function logic [7:0] pat(input int k);
        return 8'h96 ^ (8'h3B + 8'(k));
    endfunction : pat
    // Feeds read bytes on request and counts refused status writes.
    always @(posedge core_clk) begin
        rd_valid <= cmd_valid | rd_req;
        rd_data <= pat(cmd_valid ? 0 : idx);
        idx <= cmd_valid ? 1 : idx + int'(rd_req);
        nblk <= nblk + int'(wr_blocked);
    end
    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // One read frame: command, address, dummy byte, two data bytes.
    task rd(input logic [7:0] op, input int ln, input logic [23:0] a);
        logic [7:0] v;
        h.start();
        h.send(op, 8);
        if (ln == 1) h.pause();
        for (int b = 2; b >= 0; b--) h.send(a[8*b+:8], 8);
        h.send(8'h00, 8);
        chk(24'(cmd_code), 24'(op));
        chk(cmd_addr, a);
        chk(24'(standby), 24'h0);
        for (int k = 0; k < 2; k++) begin
            h.recv(ln, v);
            chk(24'(v), 24'(pat(k)));
        end
        h.stop();
        repeat (5) @(posedge core_clk);
        chk(24'(io_oe_n), 24'hF);
        chk(24'(standby), 24'h1);
    endtask : rd
    // One status write frame.
    task wrs(input logic [7:0] v);
        h.start();
        h.send(8'h01, 8);
        h.send(v, 8);
        h.stop();
        repeat (5) @(posedge core_clk);
    endtask : wrs
    initial begin
        // A real reset edge is needed, since the link logic only sees edges.
        rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(24'(standby), 24'h1);
        chk(24'(io_oe_n), 24'hF);
        h.set_wp(1'b0);
        wrs(8'h7F);
        chk(24'({nblk[0], st}), 24'h80);
        h.set_wp(1'b1);
        wrs(8'h2D);
        chk(24'(st), 24'h2D);
        h.start();
        h.send(8'hFF, 4);
        h.stop();
        rd(8'h03, 1, 24'h123456);
        rd(8'h3B, 2, 24'hABCDEF);
        wrs(8'h40);
        h.set_wp(1'b0);
        wrs(8'h47);
        chk(24'({nblk[0], st}), 24'hC7);
        rd(8'h6B, 4, 24'h000001);
        busy <= 1'b1;
        h.start();
        h.stop();
        repeat (5) @(posedge core_clk);
        chk(24'(standby), 24'h0);
        busy <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(24'(standby), 24'h1);
        tally_and_finish();
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        #200000;
        fails++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : sfpi_top_tb
